// [rtl/dual_operand_logic_unit.sv]
/*
  two-operand logic and compare unit with apb register access.
  assumes operands come from logic on core_clk with a good flag each,
  and an apb master on the same clock.
*/
// Overview of operation
// - output is one bit; each operand is high at or above one half
// - each operand has its own invert setting
// - operation off performs no function; output stays low
// - and: high only when both levels are high
// - or: high when either or both levels are high
// - xor: high when exactly one level is high
// - latch: while operand two high, output follows operand one
// - latch: after two falls, take next transition of one, hold it
// - equal: high when both values are equal
// - unequal: high when values differ
// - greater: high when value one strictly exceeds value two
// - less: high when value one is strictly below value two
// - greater or equal: high when value one not below value two
// - less or equal: high when value one does not exceed value two
// - a bad operand forces output value and status from fallback select
// - comparisons hold their result within a hysteresis band h
// - equality ignores hysteresis
// - a good or bad status accompanies the output value
`timescale 1ns/1ps
module dual_operand_logic_unit
  import logic_unit_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire operand_s operand_one,
  input wire operand_s operand_two,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output result_s result
);
  function automatic logic signed [EXT_W-1:0] ext(input logic signed [DATA_W-1:0] v);
    ext = {{2{v[DATA_W-1]}}, v};
  endfunction : ext

  logic [CTRL_W-1:0] ctrl_r;
  logic [DATA_W-1:0] hyst_r;
  logic [31:0] prdata_r;
  result_s result_r;
  result_s result_nxt;
  logic cmp_r;
  logic cmp_nxt;
  logic lvl1_prev_r;
  latch_state_e lat_r;
  latch_state_e lat_nxt;
  logic lat_out_nxt;

  wire op_t op = ctrl_r[CTRL_OP_LSB +: OP_W];
  wire fall_t fall_sel = ctrl_r[CTRL_FALL_LSB +: 2];
  wire inv1 = ctrl_r[CTRL_INV1_BIT];
  wire inv2 = ctrl_r[CTRL_INV2_BIT];
  logic lvl1;
  logic lvl2;

  operand_level u_level_one (
    .value(operand_one.value),
    .invert(inv1),
    .level(lvl1)
  );

  operand_level u_level_two (
    .value(operand_two.value),
    .invert(inv2),
    .level(lvl2)
  );

  // apb decode
  wire sel_ctrl = (paddr == CTRL_OFS);
  wire sel_hyst = (paddr == HYST_OFS);
  wire sel_stat = (paddr == STAT_OFS);
  wire mapped = sel_ctrl | sel_hyst | sel_stat;
  wire access = psel & penable;
  wire setup = psel & ~penable;
  wire wr_ok = access & pwrite & (sel_ctrl | sel_hyst);
  logic [31:0] stat_word;

  always_comb begin
    stat_word = 32'h00000000;
    stat_word[STAT_OUT_BIT] = result_r.value;
    stat_word[STAT_GOOD_BIT] = result_r.good;
    stat_word[STAT_G1_BIT] = operand_one.good;
    stat_word[STAT_G2_BIT] = operand_two.good;
    stat_word[STAT_L1_BIT] = lvl1;
    stat_word[STAT_L2_BIT] = lvl2;
  end

  wire [31:0] rd_word = sel_ctrl ? {24'h000000, ctrl_r} :
                        sel_hyst ? {16'h0000, hyst_r} :
                        sel_stat ? stat_word : 32'h00000000;

  // read data is captured in the setup cycle, so no wait state is needed
  assign pready = access;
  assign pslverr = access & (~mapped | (pwrite & sel_stat));
  assign prdata = prdata_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= 32'h00000000;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h00000000 : rd_word;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RESET;
      hyst_r <= HYST_RESET;
    end else if (wr_ok) begin
      if (sel_ctrl) begin
        ctrl_r <= pwdata[CTRL_W-1:0];
      end
      if (sel_hyst) begin
        hyst_r <= pwdata[DATA_W-1:0];
      end
    end
  end

  // comparison operands widened so that b - h and b + h cannot wrap
  wire signed [EXT_W-1:0] a_x = ext(operand_one.value);
  wire signed [EXT_W-1:0] b_x = ext(operand_two.value);
  wire signed [EXT_W-1:0] h_x = {2'b00, hyst_r};
  wire signed [EXT_W-1:0] b_lo = b_x - h_x;
  wire signed [EXT_W-1:0] b_hi = b_x + h_x;
  wire hyst_zero = (hyst_r == HYST_RESET);
  wire a_eq = (a_x == b_x);
  wire a_gt = (a_x > b_x);
  wire a_lt = (a_x < b_x);
  wire drop_lo = hyst_zero | (a_x < b_lo);
  wire drop_hi = hyst_zero | (a_x > b_hi);
  wire is_cmp = (op == OP_GT) | (op == OP_LT) | (op == OP_GE) | (op == OP_LE);

  always_comb begin
    cmp_nxt = cmp_r;
    unique case (op)
      OP_GT: begin
        if (a_gt) cmp_nxt = 1'b1;
        else if (drop_lo) cmp_nxt = 1'b0;
      end
      OP_GE: begin
        if (!a_lt) cmp_nxt = 1'b1;
        else if (drop_lo) cmp_nxt = 1'b0;
      end
      OP_LT: begin
        if (a_lt) cmp_nxt = 1'b1;
        else if (drop_hi) cmp_nxt = 1'b0;
      end
      OP_LE: begin
        if (!a_gt) cmp_nxt = 1'b1;
        else if (drop_hi) cmp_nxt = 1'b0;
      end
      default: cmp_nxt = 1'b0;
    endcase
  end

  always_comb begin
    lat_nxt = lat_r;
    lat_out_nxt = result_r.value;
    unique case (lat_r)
      LAT_FOLLOW: begin
        if (lvl2) lat_out_nxt = lvl1;
        else lat_nxt = LAT_ARMED;
      end
      LAT_ARMED: begin
        if (lvl2) begin
          lat_out_nxt = lvl1;
          lat_nxt = LAT_FOLLOW;
        end else if (lvl1 != lvl1_prev_r) begin
          lat_out_nxt = lvl1;
          lat_nxt = LAT_HELD;
        end
      end
      LAT_HELD: begin
        if (lvl2) begin
          lat_out_nxt = lvl1;
          lat_nxt = LAT_FOLLOW;
        end
      end
      default: lat_nxt = LAT_FOLLOW;
    endcase
  end

  wire both_good = operand_one.good & operand_two.good;

  always_comb begin
    result_nxt.good = 1'b1;
    unique case (op)
      OP_AND: result_nxt.value = lvl1 & lvl2;
      OP_OR: result_nxt.value = lvl1 | lvl2;
      OP_XOR: result_nxt.value = lvl1 ^ lvl2;
      OP_LATCH: result_nxt.value = lat_out_nxt;
      OP_EQ: result_nxt.value = a_eq;
      OP_NE: result_nxt.value = ~a_eq;
      OP_GT, OP_LT, OP_GE, OP_LE: result_nxt.value = cmp_nxt;
      default: result_nxt.value = 1'b0;
    endcase
    if (!both_good) begin
      result_nxt.value = fall_sel[FALL_VALUE_BIT];
      result_nxt.good = ~fall_sel[FALL_BAD_BIT];
    end
  end

  // the latch and band keep updating from the operand values while an operand is bad
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lat_r <= LAT_FOLLOW;
      lvl1_prev_r <= 1'b0;
      cmp_r <= 1'b0;
    end else begin
      lat_r <= (op == OP_LATCH) ? lat_nxt : LAT_FOLLOW;
      lvl1_prev_r <= lvl1;
      cmp_r <= cmp_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      result_r <= '{value: 1'b0, good: 1'b1};
    end else begin
      result_r <= result_nxt;
    end
  end

  assign result = result_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  and_result_a: assert property (op == OP_AND && both_good |=>
    result.value == $past(lvl1 & lvl2)) else $error("and result wrong");
  or_result_a: assert property (op == OP_OR && both_good |=>
    result.value == $past(lvl1 | lvl2)) else $error("or result wrong");
  xor_result_a: assert property (op == OP_XOR && both_good |=>
    result.value == $past(lvl1 ^ lvl2)) else $error("xor result wrong");
  off_low_a: assert property (op == OP_OFF && both_good |=>
    !result.value && result.good) else $error("off not low");
  level_half_a: assert property (op == OP_AND && both_good && !inv1 && !inv2 &&
    operand_one.value >= LEVEL_HALF && operand_two.value >= LEVEL_HALF |=> result.value)
    else $error("half threshold not high");
  invert_one_a: assert property (op == OP_AND && both_good && inv1 && !inv2 &&
    operand_one.value < LEVEL_HALF && operand_two.value >= LEVEL_HALF |=> result.value)
    else $error("inverted operand not high");
  latch_follow_a: assert property (op == OP_LATCH && both_good &&
    lat_r == LAT_FOLLOW && lvl2 |=> result.value == $past(lvl1))
    else $error("latch not following");
  latch_hold_a: assert property (op == OP_LATCH && $past(op) == OP_LATCH &&
    both_good && lat_r == LAT_HELD && !lvl2 |=> $stable(result.value))
    else $error("latch not holding");
  eq_plain_a: assert property (op == OP_EQ && both_good |=>
    result.value == $past(operand_one.value == operand_two.value)) else $error("eq wrong");
  ne_plain_a: assert property (op == OP_NE && both_good |=>
    result.value == $past(operand_one.value != operand_two.value)) else $error("ne wrong");
  gt_set_a: assert property (op == OP_GT && both_good &&
    operand_one.value > operand_two.value |=> result.value) else $error("gt not set");
  lt_set_a: assert property (op == OP_LT && both_good &&
    operand_one.value < operand_two.value |=> result.value) else $error("lt not set");
  ge_set_a: assert property (op == OP_GE && both_good &&
    operand_one.value >= operand_two.value |=> result.value) else $error("ge not set");
  le_set_a: assert property (op == OP_LE && both_good &&
    operand_one.value <= operand_two.value |=> result.value) else $error("le not set");
  gt_band_a: assert property (op == OP_GT && $past(op) == OP_GT && $past(both_good) &&
    both_good && result.value && (a_gt || (!hyst_zero && a_x >= b_lo)) |=> result.value)
    else $error("gt band dropped early");
  ge_band_a: assert property (op == OP_GE && $past(op) == OP_GE && $past(both_good) &&
    both_good && result.value && (!a_lt || (!hyst_zero && a_x >= b_lo)) |=> result.value)
    else $error("ge band dropped early");
  lt_band_a: assert property (op == OP_LT && $past(op) == OP_LT && $past(both_good) &&
    both_good && result.value && (a_lt || (!hyst_zero && a_x <= b_hi)) |=> result.value)
    else $error("lt band dropped early");
  le_band_a: assert property (op == OP_LE && $past(op) == OP_LE && $past(both_good) &&
    both_good && result.value && (!a_gt || (!hyst_zero && a_x <= b_hi)) |=> result.value)
    else $error("le band dropped early");

  gt_clear_a: assert property (op == OP_GT && both_good && a_x < b_lo |=>
    !result.value) else $error("gt band not cleared");
  ge_clear_a: assert property (op == OP_GE && both_good && a_x < b_lo |=>
    !result.value) else $error("ge band not cleared");
  lt_clear_a: assert property (op == OP_LT && both_good && a_x > b_hi |=>
    !result.value) else $error("lt band not cleared");
  le_clear_a: assert property (op == OP_LE && both_good && a_x > b_hi |=>
    !result.value) else $error("le band not cleared");

  eq_no_band_a: assert property (op == OP_EQ && both_good && !hyst_zero &&
    operand_one.value != operand_two.value |=> !result.value) else $error("eq used band");

  latch_capture_a: assert property (op == OP_LATCH && $past(op) == OP_LATCH &&
    both_good && lat_r == LAT_ARMED && !lvl2 && $changed(lvl1) |=> result.value == $past(lvl1))
    else $error("latch missed transition");

  ctrl_write_a: assert property (psel && penable && pwrite && paddr == CTRL_OFS |=>
    ctrl_r == $past(pwdata[CTRL_W-1:0])) else $error("ctrl write lost");
  ctrl_read_a: assert property (psel && penable && !pwrite && paddr == CTRL_OFS |->
    prdata == {24'h000000, ctrl_r}) else $error("ctrl read wrong");
  hyst_write_a: assert property (psel && penable && pwrite && paddr == HYST_OFS |=>
    hyst_r == $past(pwdata[DATA_W-1:0])) else $error("band write lost");
  unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access accepted");

  stat_read_a: assert property (psel && penable && !pwrite && paddr == STAT_OFS |->
    prdata[STAT_OUT_BIT] == $past(result.value) &&
    prdata[STAT_GOOD_BIT] == $past(result.good)) else $error("status read wrong");
  stat_ro_a: assert property (psel && penable && pwrite && paddr == STAT_OFS |=>
    $stable(ctrl_r) && $stable(hyst_r)) else $error("status write not ignored");

  fallback_a: assert property (!both_good |=>
    result.value == $past(fall_sel[FALL_VALUE_BIT]) &&
    result.good == !$past(fall_sel[FALL_BAD_BIT])) else $error("fallback wrong");
  good_status_a: assert property (both_good |=> result.good)
    else $error("status bad with good operands");
  reset_off_a: assert property ($rose(resetn) |-> op == OP_OFF && !result.value)
    else $error("reset not off");

  latch_capture_c: cover property (op == OP_LATCH && lat_r == LAT_ARMED ##1 lat_r == LAT_HELD);
  gt_hold_c: cover property (op == OP_GT && is_cmp && result.value && !a_gt ##1 result.value);
  fallback_c: cover property (both_good ##1 !both_good);
  apb_write_c: cover property (wr_ok && sel_ctrl);
  latch_return_c: cover property (op == OP_LATCH && lat_r == LAT_HELD ##1 lat_r == LAT_FOLLOW);
endmodule : dual_operand_logic_unit

// [rtl/logic_unit_pkg.sv]
/*
  constants, field layout and carrier types of the two-operand logic and compare unit.
  assumes operands are signed fixed point values with FRAC_W fraction bits.
*/
package logic_unit_pkg;
  localparam int DATA_W = 16;
  localparam int FRAC_W = 8;
  localparam int ADDR_W = 12;
  localparam int OP_W = 4;
  localparam int EXT_W = DATA_W + 2;
  // one half at FRAC_W fraction bits
  localparam logic signed [DATA_W-1:0] LEVEL_HALF = 16'sh0080;

  typedef struct packed {
    logic signed [DATA_W-1:0] value;
    logic good;
  } operand_s;

  typedef struct packed {
    logic value;
    logic good;
  } result_s;

  typedef logic [OP_W-1:0] op_t;
  localparam op_t OP_OFF = 4'h0;
  localparam op_t OP_AND = 4'h1;
  localparam op_t OP_OR = 4'h2;
  localparam op_t OP_XOR = 4'h3;
  localparam op_t OP_LATCH = 4'h4;
  localparam op_t OP_EQ = 4'h5;
  localparam op_t OP_NE = 4'h6;
  localparam op_t OP_GT = 4'h7;
  localparam op_t OP_LT = 4'h8;
  localparam op_t OP_GE = 4'h9;
  localparam op_t OP_LE = 4'hA;

  // bit 1 is the value, bit 0 marks status bad
  typedef logic [1:0] fall_t;
  localparam fall_t FALLBACK_LOW_VALID = 2'h0;
  localparam fall_t FALLBACK_LOW_INVALID = 2'h1;
  localparam fall_t FALLBACK_HIGH_VALID = 2'h2;
  localparam fall_t FALLBACK_HIGH_INVALID = 2'h3;
  localparam int FALL_VALUE_BIT = 1;
  localparam int FALL_BAD_BIT = 0;

  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] HYST_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] STAT_OFS = 12'h008;

  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_INV1_BIT = 4;
  localparam int CTRL_INV2_BIT = 5;
  localparam int CTRL_FALL_LSB = 6;
  localparam int CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] HYST_RESET = 16'h0000;

  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_GOOD_BIT = 1;
  localparam int STAT_G1_BIT = 2;
  localparam int STAT_G2_BIT = 3;
  localparam int STAT_L1_BIT = 4;
  localparam int STAT_L2_BIT = 5;

  typedef enum logic [2:0] {
    LAT_FOLLOW = 3'b001,
    LAT_ARMED = 3'b010,
    LAT_HELD = 3'b100
  } latch_state_e;
endpackage : logic_unit_pkg

// [rtl/operand_level.sv]
/*
  threshold and optional inversion of one operand into a logic level.
  assumes a value already on core_clk; purely combinational.
*/
`timescale 1ns/1ps
module operand_level
  import logic_unit_pkg::*;
(
  input wire logic signed [DATA_W-1:0] value,
  input wire logic invert,
  output logic level
);
  logic at_or_above_half;

  assign at_or_above_half = (value >= LEVEL_HALF);
  assign level = at_or_above_half ^ invert;
endmodule : operand_level

// [sim/operand_source.sv]
/*
  upstream model: hands two operands, each with a good flag, to the unit.
  assumes the bench sets next values just after a rising core_clk edge.
*/
`timescale 1ns/1ps
module operand_source
  import logic_unit_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire operand_s next_one,
  input wire operand_s next_two,
  output operand_s operand_one,
  output operand_s operand_two
);
  // value with good flag
  // registered like a real upstream block, so one cycle passes before the unit sees it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      operand_one <= '{value: '0, good: 1'b1};
      operand_two <= '{value: '0, good: 1'b1};
    end else begin
      operand_one <= next_one;
      operand_two <= next_two;
    end
  end
endmodule : operand_source

// [sim/two_input_logic_compare_operator_test.sv]
/*
  self-checking bench of the two-operand logic and compare unit.
  assumes zero-wait apb, operands through operand_source, result one cycle late.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module two_input_logic_compare_operator_test;
  import logic_unit_pkg::*;
  logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, e, x;
  operand_s operand_one, operand_two;
  operand_s n1 = '{value: '0, good: 1'b1}, n2 = '{value: '0, good: 1'b1};
  result_s result;
  int n_mismatch = 0, n_tests = 0;
  logic signed [DATA_W-1:0] av [3] = '{-16'sh0100, 16'sh0100, 16'sh0200};
  always #2 core_clk = ~core_clk;
  operand_source src (.core_clk(core_clk), .resetn(resetn), .next_one(n1),
    .next_two(n2), .operand_one(operand_one), .operand_two(operand_two));
  dual_operand_logic_unit dut (.core_clk(core_clk), .resetn(resetn),
    .operand_one(operand_one), .operand_two(operand_two), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .result(result));
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic setop(input op_t op, input logic [1:0] inv, input fall_t f);
    apb(1, CTRL_OFS, {24'h0, f, inv, op});
  endtask : setop
  task automatic go(input logic signed [DATA_W-1:0] a, b, input logic g1, g2);
    @(posedge core_clk);
    n1 <= '{value: a, good: g1};
    n2 <= '{value: b, good: g2};
    repeat (2) @(posedge core_clk);
    #1;
  endtask : go
  task automatic give_verdict;
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #40000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1;
    #1;
    `CHK("reset result", 2'b01, result)
    apb(0, CTRL_OFS, 0);
    `CHK("ctrl reset", 32'h0, q)
    `CHK("ctrl err", 1'b0, e)
    apb(0, 12'h00C, 0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    apb(1, STAT_OFS, 32'hFF);
    `CHK("status ro err", 1'b1, e)
    // logic ops and off, every invert setting, both sides of the threshold
    for (int op = 0; op < 4; op++) begin
      for (int inv = 0; inv < 4; inv++) begin
        setop(op_t'(op), inv[1:0], FALLBACK_LOW_VALID);
        for (int i = 0; i < 4; i++) begin
          logic l1, l2;
          l1 = i[0] ^ inv[0];
          l2 = i[1] ^ inv[1];
          x = (op == 1) ? (l1 & l2) : (op == 2) ? (l1 | l2) : (op == 3) ? (l1 ^ l2) : 1'b0;
          go(i[0] ? 16'sh0080 : 16'sh007F, i[1] ? 16'sh0100 : -16'sh0100, 1, 1);
          `CHK("logic", {x, 1'b1}, result)
        end
      end
    end
    // comparisons without a band
    for (int op = 5; op < 11; op++) begin
      setop(op_t'(op), 2'b11, FALLBACK_LOW_VALID);
      for (int i = 0; i < 3; i++) begin
        x = (op == 5) ? (i == 1) : (op == 6) ? (i != 1) : (op == 7) ? (i == 2) :
            (op == 8) ? (i == 0) : (op == 9) ? (i != 0) : (i != 2);
        go(av[i], 16'sh0100, 1, 1);
        `CHK("compare", {x, 1'b1}, result)
      end
    end
    // greater than with a band of 0x40, then equality ignoring it
    apb(1, HYST_OFS, 32'h40);
    apb(0, HYST_OFS, 0);
    `CHK("hyst read", 32'h40, q)
    setop(OP_GT, 2'b00, FALLBACK_LOW_VALID);
    go(16'sh0200, 16'sh0100, 1, 1);
    `CHK("hyst set", 2'b11, result)
    go(16'sh00C0, 16'sh0100, 1, 1);
    `CHK("hyst hold", 2'b11, result)
    go(16'sh00BF, 16'sh0100, 1, 1);
    `CHK("hyst clear", 2'b01, result)
    go(16'sh0100, 16'sh0100, 1, 1);
    `CHK("hyst low", 2'b01, result)
    setop(OP_EQ, 2'b00, FALLBACK_LOW_VALID);
    go(16'sh0101, 16'sh0100, 1, 1);
    `CHK("eq no band", 2'b01, result)
    go(16'sh0100, 16'sh0100, 1, 1);
    `CHK("eq match", 2'b11, result)
    // bad operand forces value and status, all four choices
    for (int f = 0; f < 4; f++) begin
      setop(OP_AND, 2'b00, fall_t'(f));
      go(16'sh0100, 16'sh0100, f[0], ~f[0]);
      `CHK("fallback", {f[1], ~f[0]}, result)
    end
    apb(0, STAT_OFS, 0);
    `CHK("status", 6'b110101, q[5:0])
    // latch: follow, arm on two low, capture next change, hold
    setop(OP_LATCH, 2'b00, FALLBACK_LOW_VALID);
    go(16'sh0100, 16'sh0100, 1, 1);
    `CHK("latch follow hi", 2'b11, result)
    go(16'sh0000, 16'sh0100, 1, 1);
    `CHK("latch follow lo", 2'b01, result)
    go(16'sh0000, 16'sh0000, 1, 1);
    `CHK("latch armed", 2'b01, result)
    go(16'sh0100, 16'sh0000, 1, 1);
    `CHK("latch capture", 2'b11, result)
    go(16'sh0000, 16'sh0000, 1, 1);
    `CHK("latch hold", 2'b11, result)
    go(16'sh0000, 16'sh0100, 1, 1);
    `CHK("latch return", 2'b01, result)
    give_verdict();
  end
endmodule : two_input_logic_compare_operator_test
